// ---- idsbx_map.vh ----
// Opcode fields, bit positions and reset values for the instruction core
`ifndef IDSBX_MAP_VH
`define IDSBX_MAP_VH

// Widths
`define IDSBX_INSTR_W 14
`define IDSBX_DATA_W 8
`define IDSBX_FADDR_W 7
`define IDSBX_PC_W 15
`define IDSBX_BRK_W 11
`define IDSBX_PAGE_W 8

// Field positions inside the instruction word and the page latch
`define IDSBX_OPHI_MSB 13
`define IDSBX_OPHI_LSB 8
`define IDSBX_OPBR_MSB 13
`define IDSBX_OPBR_LSB 11
`define IDSBX_DEST_BIT 7
`define IDSBX_FADDR_MSB 6
`define IDSBX_LIT_MSB 7
`define IDSBX_BRK_MSB 10
`define IDSBX_PAGE_MSB 6
`define IDSBX_PAGE_LSB 3

// Opcode codes, upper six bits unless noted
`define IDSBX_OP_DEC_FILE 6'h03
`define IDSBX_OP_DECSZ 6'h0B
`define IDSBX_OP_INC_FILE 6'h0A
`define IDSBX_OP_INCSZ 6'h0F
`define IDSBX_OP_ORLIT 6'h38
// Branch uses the upper three bits only
`define IDSBX_OP_BRANCH 3'h5

// Arithmetic unit modes
`define IDSBX_ALU_DEC 2'h0
`define IDSBX_ALU_INC 2'h1
`define IDSBX_ALU_OR 2'h2

// Reset values and counter steps
`define IDSBX_PC_RST 15'h0000
`define IDSBX_W_RST 8'h00
`define IDSBX_Z_RST 1'b0
`define IDSBX_PC_STEP 15'h0001
`define IDSBX_PC_SKIP 15'h0002

`endif

// ---- idsbx_alu.v ----
// Combinational decrement, increment and OR unit with zero detect
`timescale 1ns/1ps
`include "idsbx_map.vh"

module idsbx_alu #(
  parameter DATA_W = 8
) (
  // Operation select
  input wire [1:0] aluMode,
  // Operands
  input wire [DATA_W-1:0] operandA,
  input wire [DATA_W-1:0] operandB,
  // Result
  output reg [DATA_W-1:0] aluResult,
  output wire aluZero
);

  always @* begin
    case (aluMode)
      `IDSBX_ALU_DEC: aluResult = operandA - {{(DATA_W-1){1'b0}}, 1'b1};
      `IDSBX_ALU_INC: aluResult = operandA + {{(DATA_W-1){1'b0}}, 1'b1};
      `IDSBX_ALU_OR: aluResult = operandA | operandB;
      default: aluResult = operandA;
    endcase
  end

  // Zero when every result bit is clear, wrap included
  assign aluZero = ~|aluResult;

endmodule

// ---- idsbx_core.v ----
// Execution core for decrement, increment, skip, branch and OR-literal
//
// Overview of operation
// - decrement_file writes f minus one to work or file by d; zero updated.
// - decrement_skip_zero decrements file 0..127, result routed by d.
// - zero result there discards next instruction as a no-op, two cycles.
// - unconditional_branch loads 11-bit immediate into counter bits 10:0.
// - branch loads counter bits 14:11 from page latch bits 6:3.
// - unconditional_branch takes two cycles; the fetched next word is unused.
// - increment_file writes f plus one to work or file by d; zero updated.
// - increment_skip_zero routes by d, flags untouched, skips on zero.
// - or_literal_into_work ORs 8-bit literal into work, zero updated.
`timescale 1ns/1ps
`include "idsbx_map.vh"

module idsbx_core (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Instruction fetched at progCounter
  input wire [`IDSBX_INSTR_W-1:0] instrWord,
  input wire instrValid,
  output wire instrTaken,
  // Program paging latch contents
  input wire [`IDSBX_PAGE_W-1:0] pageLatch,
  // File register read port
  output wire [`IDSBX_FADDR_W-1:0] fileRdAddr,
  input wire [`IDSBX_DATA_W-1:0] fileRdData,
  // File register write port
  output reg fileWrEn,
  output reg [`IDSBX_FADDR_W-1:0] fileWrAddr,
  output reg [`IDSBX_DATA_W-1:0] fileWrData,
  // Core state
  output reg [`IDSBX_PC_W-1:0] progCounter,
  output reg [`IDSBX_DATA_W-1:0] workReg,
  output reg zeroFlag,
  output reg nopCycle
);

  // Sequencer states
  localparam ST_EXEC = 1'b0;
  localparam ST_NOP = 1'b1;

  reg state;
  reg next_state;

  // Decoded fields
  wire [5:0] opHi;
  wire [2:0] opBr;
  wire destFile;
  wire [`IDSBX_DATA_W-1:0] literal;
  wire [`IDSBX_BRK_W-1:0] branchLow;
  wire [3:0] branchHigh;
  wire [`IDSBX_PC_W-1:0] branchTarget;

  assign opHi = instrWord[`IDSBX_OPHI_MSB:`IDSBX_OPHI_LSB];
  assign opBr = instrWord[`IDSBX_OPBR_MSB:`IDSBX_OPBR_LSB];
  assign destFile = instrWord[`IDSBX_DEST_BIT];
  assign literal = instrWord[`IDSBX_LIT_MSB:0];
  assign branchLow = instrWord[`IDSBX_BRK_MSB:0];
  assign branchHigh = pageLatch[`IDSBX_PAGE_MSB:`IDSBX_PAGE_LSB];

  // Upper counter bits come from latch bits 6:3, the full four-bit field
  assign branchTarget = {branchHigh, branchLow};

  // Instruction class decode
  wire isDec;
  wire isDecSz;
  wire isInc;
  wire isIncSz;
  wire isOrLit;
  wire isBranch;
  wire isFileOp;
  wire isSkipOp;

  assign isDec = (opHi == `IDSBX_OP_DEC_FILE);
  assign isDecSz = (opHi == `IDSBX_OP_DECSZ);
  assign isInc = (opHi == `IDSBX_OP_INC_FILE);
  assign isIncSz = (opHi == `IDSBX_OP_INCSZ);
  assign isOrLit = (opHi == `IDSBX_OP_ORLIT);
  assign isBranch = (opBr == `IDSBX_OP_BRANCH);
  assign isFileOp = isDec | isDecSz | isInc | isIncSz;
  assign isSkipOp = isDecSz | isIncSz;

  // File operand address comes straight from the instruction
  assign fileRdAddr = instrWord[`IDSBX_FADDR_MSB:0];

  // Execution happens only outside the discard cycle
  wire exec;
  assign exec = instrValid && (state == ST_EXEC);
  assign instrTaken = exec;

  // Arithmetic unit selection
  reg [1:0] aluMode;
  wire [`IDSBX_DATA_W-1:0] operandA;
  wire [`IDSBX_DATA_W-1:0] aluResult;
  wire aluZero;

  always @* begin
    if (isDec || isDecSz) begin
      aluMode = `IDSBX_ALU_DEC;
    end else if (isInc || isIncSz) begin
      aluMode = `IDSBX_ALU_INC;
    end else begin
      aluMode = `IDSBX_ALU_OR;
    end
  end

  // OR-literal takes the work register, all others the file operand
  assign operandA = isOrLit ? workReg : fileRdData;

  idsbx_alu #(
    .DATA_W(`IDSBX_DATA_W)
  ) alu (
    .aluMode(aluMode),
    .operandA(operandA),
    .operandB(literal),
    .aluResult(aluResult),
    .aluZero(aluZero)
  );

  // Skip decision from the freshly computed result
  wire skipTaken;
  assign skipTaken = isSkipOp && aluZero;

  // Which side effects this instruction has
  wire writesFile;
  wire writesWork;
  wire touchesZero;

  // Destination bit picks file (1) or work register (0)
  assign writesFile = isFileOp && destFile;
  assign writesWork = (isFileOp && !destFile) || isOrLit;

  // Skip forms leave status alone
  assign touchesZero = isDec || isInc || isOrLit;

  // Next program counter
  reg [`IDSBX_PC_W-1:0] next_progCounter;

  always @* begin
    next_progCounter = progCounter;
    if (exec) begin
      if (isBranch) begin
        next_progCounter = branchTarget;
      end else if (skipTaken) begin
        // Step over the discarded word
        next_progCounter = progCounter + `IDSBX_PC_SKIP;
      end else begin
        next_progCounter = progCounter + `IDSBX_PC_STEP;
      end
    end
  end

  // Sequencer: branch and taken skip insert one no-op cycle
  always @* begin
    case (state)
      ST_EXEC: begin
        if (exec && (isBranch || skipTaken)) begin
          next_state = ST_NOP;
        end else begin
          next_state = ST_EXEC;
        end
      end
      ST_NOP: begin
        next_state = ST_EXEC;
      end
      default: begin
        next_state = ST_EXEC;
      end
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_EXEC;
      nopCycle <= 1'b0;
    end else begin
      state <= next_state;
      nopCycle <= next_state;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      progCounter <= `IDSBX_PC_RST;
    end else begin
      progCounter <= next_progCounter;
    end
  end

  // Work register and zero flag
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      workReg <= `IDSBX_W_RST;
      zeroFlag <= `IDSBX_Z_RST;
    end else if (exec) begin
      if (writesWork) begin
        workReg <= aluResult;
      end
      if (touchesZero) begin
        zeroFlag <= aluZero;
      end
    end
  end

  // File write-back, one-cycle strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fileWrEn <= 1'b0;
      fileWrAddr <= {`IDSBX_FADDR_W{1'b0}};
      fileWrData <= {`IDSBX_DATA_W{1'b0}};
    end else begin
      fileWrEn <= exec && writesFile;
      if (exec && writesFile) begin
        fileWrAddr <= fileRdAddr;
        fileWrData <= aluResult;
      end
    end
  end

endmodule

// ---- idsbx_core_sva.sv ----
// Assertions on the execution core ports
`timescale 1ns/1ps
module idsbx_core_sva (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Instruction and latch
  input wire [13:0] instrWord,
  input wire instrValid,
  input wire instrTaken,
  input wire [7:0] pageLatch,
  // File port
  input wire [6:0] fileRdAddr,
  input wire [7:0] fileRdData,
  input wire fileWrEn,
  input wire [6:0] fileWrAddr,
  input wire [7:0] fileWrData,
  // State
  input wire [14:0] progCounter,
  input wire [7:0] workReg,
  input wire zeroFlag,
  input wire nopCycle
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire tk = instrValid && !nopCycle;
  wire [5:0] op = instrWord[13:8];
  wire d = instrWord[7];
  wire isInc = op == 6'h0A || op == 6'h0F;
  wire isSkip = op == 6'h0B || op == 6'h0F;
  wire [7:0] res = isInc ? fileRdData + 8'h01 : fileRdData - 8'h01;
  AST_DEC_F: assert property (tk && op == 6'h03 && d |=>
    fileWrEn && fileWrData == $past(res) && fileWrAddr == $past(fileRdAddr))
    else $error("decrement to file wrong");
  AST_DEC_W: assert property (tk && op == 6'h03 && !d |=>
    !fileWrEn && workReg == $past(res)) else $error("decrement to work wrong");
  AST_ZERO: assert property (tk && (op == 6'h03 || op == 6'h0A) |=>
    zeroFlag == ($past(res) == 8'h00)) else $error("zero flag wrong");
  AST_SKIP: assert property (tk && isSkip && res == 8'h00 |=>
    nopCycle && progCounter == $past(progCounter) + 15'h0002 ##1 !nopCycle)
    else $error("skip timing wrong");
  AST_NOSKIP: assert property (tk && isSkip && res != 8'h00 |=>
    !nopCycle && progCounter == $past(progCounter) + 15'h0001)
    else $error("no skip wrong");
  AST_SKIP_FLAG: assert property (tk && isSkip |=>
    $stable(zeroFlag)) else $error("skip touched zero");
  AST_BRANCH: assert property (tk && instrWord[13:11] == 3'h5 |=>
    nopCycle && progCounter == {$past(pageLatch[6:3]), $past(instrWord[10:0])})
    else $error("branch target wrong");
  AST_OR: assert property (tk && op == 6'h38 |=>
    workReg == ($past(workReg) | $past(instrWord[7:0]))
    && zeroFlag == (workReg == 8'h00)) else $error("or literal wrong");
  AST_NOP: assert property (nopCycle |-> !instrTaken ##1 !nopCycle)
    else $error("no-op cycle wrong");
  COV_SKIP: cover property (tk && isSkip && res == 8'h00);
  COV_BRANCH: cover property (tk && instrWord[13:11] == 3'h5);
  COV_OR: cover property (tk && op == 6'h38);
endmodule
bind idsbx_core idsbx_core_sva chk (.clk_sys(clk_sys), .rst(rst),
  .instrWord(instrWord), .instrValid(instrValid), .instrTaken(instrTaken),
  .pageLatch(pageLatch), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
  .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
  .progCounter(progCounter), .workReg(workReg), .zeroFlag(zeroFlag),
  .nopCycle(nopCycle));

// ---- inc_dec_skip_branch_exec_tb.sv ----
// Self-checking bench for the execution core
`timescale 1ns/1ps
module inc_dec_skip_branch_exec_tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [13:0] instrWord = 14'h0000;
  reg instrValid = 1'b0;
  reg [7:0] pageLatch = 8'h00;
  reg [7:0] fileRdData = 8'h00;
  wire instrTaken, fileWrEn, zeroFlag, nopCycle;
  wire [6:0] fileRdAddr, fileWrAddr;
  wire [7:0] fileWrData, workReg;
  wire [14:0] progCounter;
  integer n_fail = 0;
  integer n_tests = 0;
  integer cycles = 0;
  reg [14:0] pc0;
  idsbx_core dut (.clk_sys(clk_sys), .rst(rst), .instrWord(instrWord),
    .instrValid(instrValid), .instrTaken(instrTaken), .pageLatch(pageLatch),
    .fileRdAddr(fileRdAddr), .fileRdData(fileRdData), .fileWrEn(fileWrEn),
    .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
    .progCounter(progCounter), .workReg(workReg), .zeroFlag(zeroFlag),
    .nopCycle(nopCycle));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task results;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [47:0] what, input [14:0] exp, input [14:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // One instruction; returns once its results have landed
  task issue(input [13:0] w, input [7:0] rd, input [7:0] pl);
    begin
      pc0 = progCounter;
      @(posedge clk_sys);
      instrWord <= w;
      fileRdData <= rd;
      pageLatch <= pl;
      instrValid <= 1'b1;
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1;
    end
  endtask
  task t_dec;
    begin
      issue(14'h0385, 8'h01, 8'h00);
      chk("wen", 15'h0001, fileWrEn);
      chk("waddr", 15'h0005, fileWrAddr);
      chk("raddr", 15'h0005, fileRdAddr);
      chk("wdata", 15'h0000, fileWrData);
      chk("zero", 15'h0001, zeroFlag);
      chk("pc", pc0 + 15'h0001, progCounter);
      issue(14'h0305, 8'h00, 8'h00);
      chk("wen", 15'h0000, fileWrEn);
      chk("work", 15'h00FF, workReg);
      chk("zero", 15'h0000, zeroFlag);
    end
  endtask
  task t_skip;
    begin
      issue(14'h0B03, 8'h01, 8'h00);
      chk("work", 15'h0000, workReg);
      chk("nop", 15'h0001, nopCycle);
      chk("pc", pc0 + 15'h0002, progCounter);
      issue(14'h0B83, 8'h05, 8'h00);
      chk("wdata", 15'h0004, fileWrData);
      chk("nop", 15'h0000, nopCycle);
      chk("pc", pc0 + 15'h0001, progCounter);
    end
  endtask
  task t_inc;
    begin
      issue(14'h0AFF, 8'hFF, 8'h00);
      chk("waddr", 15'h007F, fileWrAddr);
      chk("zero", 15'h0001, zeroFlag);
      issue(14'h0A00, 8'h07, 8'h00);
      chk("work", 15'h0008, workReg);
      chk("zero", 15'h0000, zeroFlag);
      // Zero result with the flag clear shows the flag is left alone
      issue(14'h0F00, 8'hFF, 8'h00);
      chk("zero", 15'h0000, zeroFlag);
      chk("work", 15'h0000, workReg);
      chk("nop", 15'h0001, nopCycle);
      chk("pc", pc0 + 15'h0002, progCounter);
    end
  endtask
  task t_or;
    begin
      // Work cleared with the flag still clear, so the OR must set it
      issue(14'h0B00, 8'h01, 8'h00);
      chk("work", 15'h0000, workReg);
      chk("zero", 15'h0000, zeroFlag);
      issue(14'h3800, 8'h00, 8'h00);
      chk("work", 15'h0000, workReg);
      chk("zero", 15'h0001, zeroFlag);
      issue(14'h38A5, 8'h00, 8'h00);
      chk("work", 15'h00A5, workReg);
      chk("zero", 15'h0000, zeroFlag);
      issue(14'h385A, 8'h00, 8'h00);
      chk("work", 15'h00FF, workReg);
      chk("zero", 15'h0000, zeroFlag);
    end
  endtask
  task t_branch;
    begin
      issue(14'h2FFF, 8'h00, 8'hA8);
      chk("pc", 15'h2FFF, progCounter);
      chk("nop", 15'h0001, nopCycle);
      issue(14'h2800, 8'h00, 8'h78);
      chk("pc", 15'h7800, progCounter);
    end
  endtask
  // Word held valid through the no-op cycle must be ignored, then taken
  task t_refuse;
    begin
      @(posedge clk_sys);
      instrWord <= 14'h2855;
      pageLatch <= 8'h00;
      instrValid <= 1'b1;
      @(posedge clk_sys);
      instrWord <= 14'h0A00;
      fileRdData <= 8'h10;
      #1;
      chk("taken", 15'h0000, instrTaken);
      chk("nop", 15'h0001, nopCycle);
      chk("pc", 15'h0055, progCounter);
      @(posedge clk_sys);
      #1;
      chk("pc", 15'h0055, progCounter);
      chk("work", 15'h00FF, workReg);
      chk("taken", 15'h0001, instrTaken);
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1;
      chk("work", 15'h0011, workReg);
      chk("pc", 15'h0056, progCounter);
      issue(14'h0000, 8'h33, 8'h00);
      chk("pc", pc0 + 15'h0001, progCounter);
      chk("work", 15'h0011, workReg);
      chk("wen", 15'h0000, fileWrEn);
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_dec;
    t_skip;
    t_inc;
    t_or;
    t_branch;
    t_refuse;
    results;
  end
endmodule
